// file: rtl/tgc_pkg.sv
// package for the transmit global control alias and transmit bit mask
// assumes a plain strobe register port with byte-addressed word offsets
package tgc_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_GLOBAL = 8'h00;
    localparam logic [7:0] ADDR_TX_ALIAS = 8'h04;
    localparam logic [7:0] ADDR_KEEP = 8'h08;
    localparam logic [7:0] ADDR_FORMAT = 8'h0C;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int TX_LSB = 8;
    localparam int TX_MSB = 12;
    localparam int RX_LSB = 0;
    localparam int RX_MSB = 4;
    localparam int PAD_LSB = 13;
    localparam int PAD_MSB = 14;
    localparam int PBIT_LSB = 8;
    localparam int PBIT_MSB = 12;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [31:0] KEEP_RESET = 32'h00000000;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [31:0] WORD_ONES = 32'hFFFFFFFF;
    localparam logic [4:0] IDX_RESET = 5'h00;

    // pad source codes
    typedef enum logic [1:0] {
        PAD_ZERO = 2'h0,
        PAD_ONE = 2'h1,
        PAD_WORD_BIT = 2'h2,
        PAD_RESERVED = 2'h3
    } tgc_pad_t;

    // five run controls of one direction, msb first
    typedef struct packed {
        logic fsyncGenRun;
        logic sequencerRun;
        logic serializersActive;
        logic hfDividerRun;
        logic bitclkDividerRun;
    } tgc_ctrl_t;

    // transmit word leaving the format unit
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } tgc_word_t;

endpackage

// file: rtl/tgc_tx_global_ctrl.sv
// transmit global control alias, shared global control and transmit mask
// assumes synchronous active-low reset and single-cycle bus strobes
//
// Operation
// - alias writes change only transmit control bits 12..8 of global control
// - alias reads return the whole global control word, receive bits included
// - transmit section reset or release leaves receive controls untouched
// - bit 12 holds transmit frame sync generator in reset when 0
// - bit 11 holds transmit sequencer in reset when 0
// - bit 10 clears transmit serializers when 0
// - bit 9 holds transmit high-frequency divider in reset when 0
// - bit 8 holds transmit bit clock divider in reset when 0
// - alias bits 4..0 show receive controls; alias writes to them ignored
// - reserved bits read zero and ignore writes
// - keep bit 0 replaces the data bit with the pad value
// - keep bit 1 passes the data bit unchanged
// - masking happens before reverse and rotate, before shifting
// - pad source 0 gives zero, 1 gives one, 2 a word bit, 3 reserved
// - five-bit index picks which written word bit supplies the pad
`timescale 1ns/1ps
`default_nettype none

module tgc_tx_global_ctrl (
    input wire logic core_clk, // 125 MHz bus clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic clkEn, // freezes all state when low
    input wire logic [7:0] regAddr, // byte address
    input wire logic [31:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [31:0] regRdata, // read data, cycle after strobe
    input var tgc_pkg::tgc_word_t txWordIn, // word as written to buffer
    output var tgc_pkg::tgc_word_t txWordOut, // masked word to reverse unit
    output var tgc_pkg::tgc_ctrl_t txCtrl, // transmit run controls
    output var tgc_pkg::tgc_ctrl_t rxCtrl // receive run controls
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    tgc_pkg::tgc_ctrl_t txCtrl_q;
    tgc_pkg::tgc_ctrl_t rxCtrl_q;
    logic [31:0] keepBits_q;
    tgc_pkg::tgc_pad_t padSource_q;
    logic [4:0] padBitIdx_q;
    logic [31:0] regRdata_q;
    tgc_pkg::tgc_word_t txWordOut_q;

    logic wrGlobal;
    logic wrAlias;
    logic wrKeep;
    logic wrFormat;
    logic [31:0] globalWord;
    logic [31:0] formatWord;
    logic padValue;
    logic [31:0] maskedWord;

    // word-sized view of a control group at a given lsb
    function automatic logic [31:0] placeCtrl(input logic [4:0] c,
                                              input int lsb);
        logic [31:0] w;
        w = tgc_pkg::WORD_ZERO;
        w[lsb +: 5] = c;
        return w;
    endfunction

    // strobes qualified by the clock enable
    assign wrGlobal = clkEn && regWr && regAddr == tgc_pkg::ADDR_GLOBAL;
    assign wrAlias = clkEn && regWr && regAddr == tgc_pkg::ADDR_TX_ALIAS;
    assign wrKeep = clkEn && regWr && regAddr == tgc_pkg::ADDR_KEEP;
    assign wrFormat = clkEn && regWr && regAddr == tgc_pkg::ADDR_FORMAT;

    // ----------------------------------------------------------------
    // shared global control
    // ----------------------------------------------------------------
    // one flip-flop per transmit bit serves both addresses
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txCtrl_q <= tgc_pkg::CTRL_RESET;
        end else if (wrGlobal || wrAlias) begin
            txCtrl_q <= regWdata[tgc_pkg::TX_MSB:tgc_pkg::TX_LSB];
        end
    end

    // receive half only moves through the global address
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxCtrl_q <= tgc_pkg::CTRL_RESET;
        end else if (wrGlobal) begin
            rxCtrl_q <= regWdata[tgc_pkg::RX_MSB:tgc_pkg::RX_LSB];
        end
    end

    // run controls go straight out; 0 means held in reset
    assign txCtrl = txCtrl_q;
    assign rxCtrl = rxCtrl_q;

    // reserved bits stay zero by construction
    assign globalWord = placeCtrl(txCtrl_q, tgc_pkg::TX_LSB)
                      | placeCtrl(rxCtrl_q, tgc_pkg::RX_LSB);

    // ----------------------------------------------------------------
    // mask and format registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            keepBits_q <= tgc_pkg::KEEP_RESET;
        end else if (wrKeep) begin
            keepBits_q <= regWdata;
        end
    end

    // reserved pad code is stored but pads with zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            padSource_q <= tgc_pkg::PAD_ZERO;
            padBitIdx_q <= tgc_pkg::IDX_RESET;
        end else if (wrFormat) begin
            padSource_q <= tgc_pkg::tgc_pad_t'(
                regWdata[tgc_pkg::PAD_MSB:tgc_pkg::PAD_LSB]);
            padBitIdx_q <= regWdata[tgc_pkg::PBIT_MSB:tgc_pkg::PBIT_LSB];
        end
    end

    assign formatWord = {17'h00000, padSource_q, padBitIdx_q, 8'h00};

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    // unmapped addresses read zero; data valid only the cycle after
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            regRdata_q <= tgc_pkg::WORD_ZERO;
        end else if (clkEn) begin
            if (regRd) begin
                unique case (regAddr)
                    tgc_pkg::ADDR_GLOBAL: regRdata_q <= globalWord;
                    tgc_pkg::ADDR_TX_ALIAS: regRdata_q <= globalWord;
                    tgc_pkg::ADDR_KEEP: regRdata_q <= keepBits_q;
                    tgc_pkg::ADDR_FORMAT: regRdata_q <= formatWord;
                    default: regRdata_q <= tgc_pkg::WORD_ZERO;
                endcase
            end else begin
                regRdata_q <= tgc_pkg::WORD_ZERO;
            end
        end
    end

    assign regRdata = regRdata_q;

    // ----------------------------------------------------------------
    // mask and pad datapath
    // ----------------------------------------------------------------
    // pad bit is picked from the word as written, not after reversal
    always_comb begin
        unique case (padSource_q)
            tgc_pkg::PAD_ZERO: padValue = 1'b0;
            tgc_pkg::PAD_ONE: padValue = 1'b1;
            tgc_pkg::PAD_WORD_BIT: padValue = txWordIn.data[padBitIdx_q];
            tgc_pkg::PAD_RESERVED: padValue = 1'b0;
        endcase
    end

    // keep bit 1 passes data, 0 substitutes pad
    assign maskedWord = (txWordIn.data & keepBits_q)
                      | ({32{padValue}} & ~keepBits_q);

    // registered hand-off to the reverse and rotate stages
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txWordOut_q <= '0;
        end else if (clkEn) begin
            txWordOut_q.valid <= txWordIn.valid;
            if (txWordIn.valid) begin
                txWordOut_q.data <= maskedWord;
            end
        end
    end

    assign txWordOut = txWordOut_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // control register writes and holds
    a_alias_tx_write: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrAlias |=>
        txCtrl_q == $past(regWdata[tgc_pkg::TX_MSB:tgc_pkg::TX_LSB]))
        else $error("alias write did not load transmit bits");

    a_alias_rx_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrAlias && !wrGlobal |=> $stable(rxCtrl_q))
        else $error("alias write disturbed receive bits");

    a_global_tx_write: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrGlobal |=>
        txCtrl_q == $past(regWdata[tgc_pkg::TX_MSB:tgc_pkg::TX_LSB]))
        else $error("global write did not load transmit bits");

    a_global_rx_write: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrGlobal |=>
        rxCtrl_q == $past(regWdata[tgc_pkg::RX_MSB:tgc_pkg::RX_LSB]))
        else $error("global write did not load receive bits");

    a_tx_hold_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !(wrGlobal || wrAlias) |=> $stable(txCtrl_q))
        else $error("transmit controls moved without a write");

    a_rx_hold_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !wrGlobal |=> $stable(rxCtrl_q))
        else $error("receive controls moved without a global write");

    // each transmit run control follows its own alias bit
    a_fsync_bit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrAlias |=>
        txCtrl.fsyncGenRun == $past(regWdata[tgc_pkg::TX_LSB + 4]))
        else $error("frame sync run control wrong");

    a_sequencer_bit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrAlias |=>
        txCtrl.sequencerRun == $past(regWdata[tgc_pkg::TX_LSB + 3]))
        else $error("sequencer run control wrong");

    a_serializer_bit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrAlias |=>
        txCtrl.serializersActive == $past(regWdata[tgc_pkg::TX_LSB + 2]))
        else $error("serializer control wrong");

    a_hf_divider_bit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrAlias |=>
        txCtrl.hfDividerRun == $past(regWdata[tgc_pkg::TX_LSB + 1]))
        else $error("high-frequency divider control wrong");

    a_bitclk_bit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrAlias |=>
        txCtrl.bitclkDividerRun == $past(regWdata[tgc_pkg::TX_LSB]))
        else $error("bit clock divider control wrong");

    // read port contents and timing
    a_alias_read_full: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && regRd && regAddr == tgc_pkg::ADDR_TX_ALIAS
        |=> regRdata == $past(globalWord))
        else $error("alias read did not return global word");

    a_alias_read_rx: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && regRd && regAddr == tgc_pkg::ADDR_TX_ALIAS
        |=> regRdata[tgc_pkg::RX_MSB:tgc_pkg::RX_LSB] == $past(rxCtrl_q))
        else $error("alias read lost receive controls");

    a_global_read: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && regRd && regAddr == tgc_pkg::ADDR_GLOBAL
        |=> regRdata == $past(globalWord))
        else $error("global read wrong");

    a_keep_read: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && regRd && regAddr == tgc_pkg::ADDR_KEEP
        |=> regRdata == $past(keepBits_q))
        else $error("keep mask read wrong");

    a_read_idle_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && !regRd |=> regRdata == tgc_pkg::WORD_ZERO)
        else $error("read data not zero outside the answer cycle");

    a_reserved_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (globalWord & ~(placeCtrl(tgc_pkg::CTRL_RESET ^ 5'h1F, tgc_pkg::TX_LSB)
        | placeCtrl(tgc_pkg::CTRL_RESET ^ 5'h1F, tgc_pkg::RX_LSB)))
        == tgc_pkg::WORD_ZERO)
        else $error("reserved control bits not zero");

    a_shared_view: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrGlobal ##1 (clkEn && regRd && regAddr == tgc_pkg::ADDR_TX_ALIAS)
        |=> regRdata[tgc_pkg::TX_MSB:tgc_pkg::TX_LSB]
        == $past(regWdata[tgc_pkg::TX_MSB:tgc_pkg::TX_LSB], 2))
        else $error("alias does not see global write");

    // mask and format registers
    a_keep_write: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrKeep |=> keepBits_q == $past(regWdata))
        else $error("keep mask write lost");

    a_format_write: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wrFormat |=>
        padBitIdx_q == $past(regWdata[tgc_pkg::PBIT_MSB:tgc_pkg::PBIT_LSB]))
        else $error("pad bit index write lost");

    // word path: pass, pad and hand-off
    a_keep_pass: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && txWordIn.valid |=>
        (txWordOut.data & $past(keepBits_q))
        == ($past(txWordIn.data) & $past(keepBits_q)))
        else $error("kept bits changed");

    a_pad_fill: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && txWordIn.valid && padSource_q == tgc_pkg::PAD_ONE |=>
        (txWordOut.data | $past(keepBits_q)) == tgc_pkg::WORD_ONES)
        else $error("masked bits not padded with one");

    a_pad_zero_fill: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && txWordIn.valid && padSource_q == tgc_pkg::PAD_ZERO |=>
        (txWordOut.data & ~$past(keepBits_q)) == tgc_pkg::WORD_ZERO)
        else $error("masked bits not padded with zero");

    a_pad_reserved: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && txWordIn.valid && padSource_q == tgc_pkg::PAD_RESERVED |=>
        (txWordOut.data & ~$past(keepBits_q)) == tgc_pkg::WORD_ZERO)
        else $error("reserved pad code did not pad zero");

    a_pad_wordbit: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && txWordIn.valid && padSource_q == tgc_pkg::PAD_WORD_BIT
        && !keepBits_q[0] |=>
        txWordOut.data[0] == $past(txWordIn.data[padBitIdx_q]))
        else $error("word bit pad wrong");

    a_valid_follow: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn |=> txWordOut.valid == $past(txWordIn.valid))
        else $error("output valid does not follow input valid");

    a_data_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        clkEn && !txWordIn.valid |=> $stable(txWordOut.data))
        else $error("output word moved without a valid input");

    // clock enable low freezes the control, mask, index, read and word registers
    a_freeze_all: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !clkEn |=> $stable(txCtrl_q) && $stable(rxCtrl_q)
        && $stable(keepBits_q) && $stable(regRdata_q)
        && $stable(txWordOut_q) && $stable(padBitIdx_q))
        else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// file: verif/tgc_far_side.sv
// far-side model: sink that takes the masked transmit word
// assumes it stands where the reverse unit would take the word
`timescale 1ns/1ps
`default_nettype none

module tgc_far_side (
    input wire logic core_clk, // bus clock
    input wire logic rst_n, // synchronous reset, active low
    input var tgc_pkg::tgc_word_t wordIn, // masked word from the block
    output logic [31:0] lastWord, // last word taken
    output logic [7:0] wordCount // words taken since reset
);
    // takes each valid word at once; the reverse unit has no backpressure
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lastWord <= 32'h00000000;
            wordCount <= 8'h00;
        end else if (wordIn.valid) begin
            lastWord <= wordIn.data;
            wordCount <= wordCount + 8'h01;
        end
    end
endmodule

`default_nettype wire

// file: verif/test_tx_global_control_and_bit_mask.sv
// self-checking bench for the transmit control alias and keep mask
// assumes one 125 MHz clock and the strobe register port of the block
`timescale 1ns/1ps
`default_nettype none

module test_tx_global_control_and_bit_mask;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h00000000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    tgc_pkg::tgc_word_t txWordIn = '0;
    tgc_pkg::tgc_word_t txWordOut;
    tgc_pkg::tgc_ctrl_t txCtrl;
    tgc_pkg::tgc_ctrl_t rxCtrl;
    logic [31:0] lastWord;
    logic [7:0] wordCount;
    int err_count = 0;
    int checked = 0;

    tgc_tx_global_ctrl dut (.core_clk(core_clk), .rst_n(rst_n),
        .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .txWordIn(txWordIn), .txWordOut(txWordOut), .txCtrl(txCtrl),
        .rxCtrl(rxCtrl));
    tgc_far_side far (.core_clk(core_clk), .rst_n(rst_n),
        .wordIn(txWordOut), .lastWord(lastWord), .wordCount(wordCount));

    // ----------------------------------------------------------------
    // shared bus cycles and comparison
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk(what, exp, regRdata);
    endtask

    task automatic send(input logic [31:0] d, input logic [31:0] exp);
        @(posedge core_clk);
        txWordIn <= '{valid: 1'b1, data: d};
        @(posedge core_clk);
        txWordIn <= '{valid: 1'b0, data: 32'h00000000};
        #1;
        chk("word valid", 32'h00000001, {31'h0, txWordOut.valid});
        chk("word data", exp, txWordOut.data);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd("global", tgc_pkg::ADDR_GLOBAL, 32'h00000000);
        rd("keep", tgc_pkg::ADDR_KEEP, 32'h00000000);
        rd("unmapped", 8'h10, 32'h00000000);
    endtask

    task automatic t_alias();
        wr(tgc_pkg::ADDR_GLOBAL, 32'h00001F1F);
        rd("global", tgc_pkg::ADDR_GLOBAL, 32'h00001F1F);
        rd("alias", tgc_pkg::ADDR_TX_ALIAS, 32'h00001F1F);
        wr(tgc_pkg::ADDR_TX_ALIAS, 32'h0000001F);
        rd("global", tgc_pkg::ADDR_GLOBAL, 32'h0000001F);
        chk("rxCtrl", 32'h1F, {27'h0, rxCtrl});
        // one transmit control at a time, receive side untouched
        for (int i = 0; i < 5; i++) begin
            wr(tgc_pkg::ADDR_TX_ALIAS, 32'h00000100 << i);
            chk("txCtrl", 32'h1 << i, {27'h0, txCtrl});
            rd("global", tgc_pkg::ADDR_GLOBAL, 32'h1F | (32'h100 << i));
        end
        wr(tgc_pkg::ADDR_GLOBAL, 32'h00000000);
        rd("alias", tgc_pkg::ADDR_TX_ALIAS, 32'h00000000);
        // strobes are ignored while the clock enable is low
        clkEn <= 1'b0;
        wr(tgc_pkg::ADDR_GLOBAL, 32'h00001F1F);
        clkEn <= 1'b1;
        rd("frozen", tgc_pkg::ADDR_GLOBAL, 32'h00000000);
    endtask

    task automatic t_mask();
        logic [31:0] d;
        logic [31:0] pad;
        d = 32'h12345678;
        wr(tgc_pkg::ADDR_KEEP, 32'hFFFF0000);
        rd("keep", tgc_pkg::ADDR_KEEP, 32'hFFFF0000);
        // every pad code, index 3 picks a one from the word
        for (int c = 0; c < 4; c++) begin
            wr(tgc_pkg::ADDR_FORMAT, (c << 13) | (3 << 8));
            pad = (c == 1) ? 32'hFFFFFFFF : (c == 2) ? {32{d[3]}} : 32'h0;
            send(d, (d & 32'hFFFF0000) | (pad & 32'h0000FFFF));
        end
        rd("format", tgc_pkg::ADDR_FORMAT, 32'h00006300);
        // top index, every bit padded
        wr(tgc_pkg::ADDR_FORMAT, 32'h00005F00);
        wr(tgc_pkg::ADDR_KEEP, 32'h00000000);
        send(32'h80000000, 32'hFFFFFFFF);
        wr(tgc_pkg::ADDR_KEEP, 32'hFFFFFFFF);
        send(32'h0F0F00F0, 32'h0F0F00F0);
        @(posedge core_clk);
        #1;
        chk("far count", 32'h6, {24'h0, wordCount});
        chk("far word", 32'h0F0F00F0, lastWord);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_alias();
        t_mask();
        results();
    end

    // the tests need well under a thousand cycles
    initial begin
        #40000;
        err_count++;
        results();
    end
endmodule

`default_nettype wire
